// [logic/tx_main_params.svh]
`ifndef TX_MAIN_PARAMS_SVH
`define TX_MAIN_PARAMS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_CLOCK_GATE    16'h4001
`define IDX_SOFT_RESET    16'h4002
`define IDX_PROT_CTRL     16'h4003
`define IDX_FEED_THROUGH  16'h4004
`define IDX_PHY_RESET     16'h4005
`define IDX_PRESENT       16'h4006
`define IDX_RETURN_PHY    16'h4007
`define IDX_PRESENT2      16'h4009
`define IDX_SOFT_RESET2   16'h400a
`define IDX_STATUS        16'h4010
`define IDX_DIV_LOW       16'h4018
`define IDX_DIV_HIGH      16'h4019

// ==========================================================
// Reset values
`define RST_CLOCK_GATE    8'h00
`define RST_OVERRIDE      1'b1
`define RST_LOCK          1'b0
`define RST_BLOCK_BYPASS  1'b0
`define RST_SWITCH        1'b1
`define RST_FEED_THROUGH  1'b0
`define RST_RETURN_PHY    1'b1
`define RST_DIV_LOW       8'h93
`define RST_DIV_HIGH      7'h69

// ==========================================================
// Field positions and fixed read patterns
`define BIT_OVERRIDE      5
`define BIT_LOCK          4
`define BIT_BLOCK_BYPASS  0
`define BIT_PAR_AUDIO     7
`define BIT_CONSUMER      6
`define SOFT_READ_LOW     7'h5f
`define PRESENT_MASK      8'hfd
`define PAR_AUDIO_SELECT  3'h6

// ==========================================================
// Domain lanes
`define LANES             12
`define LANE_CONSUMER     5
`define LANE_PAR_AUDIO    6
`define LANE_DMA          7
`define LANE_PROT14       10
`define LANE_PROT22       11

`endif

// [logic/tx_main_pkg.sv]
package tx_main_pkg;

	typedef struct packed {
		logic        hsel;
		logic [1:0]  htrans;
		logic [31:0] haddr;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
	} ahb_req_type;

	typedef struct packed {
		logic override;
		logic lock;
		logic blockBypass;
	} prot_ctrl_type;

	typedef enum logic {BUS_IDLE, BUS_WAIT} bus_state_type;

endpackage : tx_main_pkg

// [logic/domain_lane.sv]
`timescale 1ns/1ns

module domain_lane (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_b,
	// Domain side
	input  wire logic domainClockPin,
	// Control from the register file
	input  wire logic gateRequest,
	input  wire logic bypassAllow,
	input  wire logic resetToggle,
	// Lane outputs
	output logic      clockEnable,
	output logic      bypassActive,
	output logic      domainReset,
	output logic      clockSeen
);

	logic pinMeta;
	logic pinSync;
	logic pinLast;
	logic seenToggle;
	logic tick;
	logic next_enable;
	logic next_bypass;
	logic next_seen;
	logic next_reset;

	assign tick = pinSync & ~pinLast;

	// ==========================================================
	// Domain-edge retiming of gate and reset toggle
	always_comb begin
		next_enable = clockEnable;
		next_bypass = bypassActive;
		next_seen   = seenToggle;
		next_reset  = domainReset;
		if (tick) begin
			next_enable = ~gateRequest;
			next_bypass = gateRequest & bypassAllow;
			next_seen   = resetToggle;
			next_reset  = resetToggle != seenToggle;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pinMeta      <= 1'b0;
			pinSync      <= 1'b0;
			pinLast      <= 1'b0;
			clockEnable  <= 1'b1;
			bypassActive <= 1'b0;
			seenToggle   <= 1'b0;
			domainReset  <= 1'b0;
			clockSeen    <= 1'b0;
		end else begin
			pinMeta      <= domainClockPin;
			pinSync      <= pinMeta;
			pinLast      <= pinSync;
			clockEnable  <= next_enable;
			bypassActive <= next_bypass;
			seenToggle   <= next_seen;
			domainReset  <= next_reset;
			clockSeen    <= tick;
		end
	end

	// ==========================================================
	// Checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	gate_hold_a: assert property (!tick |=> $stable(clockEnable))
		else $error("gate changed without a domain edge");
	reset_pulse_a: assert property ((tick && resetToggle != seenToggle) |=> domainReset)
		else $error("toggle did not raise a domain reset");
	single_pulse_a: assert property ((tick && resetToggle == seenToggle) |=> !domainReset)
		else $error("domain reset without a new toggle");
	reset_hold_a: assert property ((domainReset && !tick) |=> domainReset)
		else $error("domain reset shorter than one domain cycle");

endmodule : domain_lane

// [logic/tx_main_clock_reset_ctrl.sv]
// Overview of operation
// - Gate bit 7 stops and bypasses newer engine
// - Gate bit 6 stops older engine, bypasses it unless bypass is blocked
// - Gate bits 5..0 stop their domain clocks
// - Writing zero toggles that domain's request line
// - Toggle becomes domain-synchronous reset, one cycle
// - Reset request bits read back as one (DMA bit as zero), bit 7 only with select 6
// - Parallel audio bit works only with select 6
// - Override picks engine version unless locked
// - Unlocked override steers the version switch
// - Lock freezes switch, cleared only by reset
// - Status bit reports switch position
`timescale 1ns/1ns
`include "tx_main_params.svh"

module tx_main_clock_reset_ctrl #(
	parameter bit PHY_GEN2 = 1'b0
) (
	// Clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   rst_b,
	// AHB-Lite slave
	input  tx_main_pkg::ahb_req_type    ahbIn,
	output logic                        hreadyout,
	output logic [31:0]                 hrdata,
	output logic                        hresp,
	// Core side
	input  wire logic [2:0]             audioInputSelect,
	input  wire logic [`LANES-1:0]      domainClockPin,
	output logic [`LANES-1:0]           laneClockEnable,
	output logic [`LANES-1:0]           laneBypass,
	output logic [`LANES-1:0]           laneReset,
	output logic [`LANES-1:0]           laneResetToggle,
	output logic                        protectVersionSel,
	output logic                        feedThrough,
	output logic                        phyReset,
	output logic                        returnPhyReset,
	output logic                        msPulse
);

	tx_main_pkg::bus_state_type busState;
	tx_main_pkg::bus_state_type next_busState;
	tx_main_pkg::prot_ctrl_type prot;
	tx_main_pkg::prot_ctrl_type next_prot;
	logic [15:0]         accIdx;
	logic                accWrite;
	logic                accMapped;
	logic [15:0]         next_accIdx;
	logic                next_accWrite;
	logic                next_accMapped;
	logic                next_ready;
	logic [31:0]         next_rdata;
	logic [7:0]          readByte;
	logic                wrEn;
	logic [7:0]          wdata;
	logic                parAudio;
	logic [7:0]          clockGate;
	logic [7:0]          next_clockGate;
	logic [7:0]          present;
	logic [7:0]          next_present;
	logic [7:0]          presentSet;
	logic                present2;
	logic                next_present2;
	logic [`LANES-1:0]   next_toggle;
	logic                next_switch;
	logic                next_feed;
	logic                next_phy;
	logic                next_returnPhy;
	logic [7:0]          divLow;
	logic [6:0]          divHigh;
	logic [7:0]          next_divLow;
	logic [6:0]          next_divHigh;
	logic [14:0]         msCount;
	logic [14:0]         next_msCount;
	logic                next_msPulse;
	logic [`LANES-1:0]   gateVec;
	logic [`LANES-1:0]   allowVec;
	logic [`LANES-1:0]   laneSeen;

	assign parAudio = audioInputSelect == `PAR_AUDIO_SELECT;
	assign wrEn     = busState == tx_main_pkg::BUS_WAIT && accWrite && accMapped;
	assign wdata    = ahbIn.hwdata[7:0];

	// ==========================================================
	// Bus slave: one wait state per transfer
	always_comb begin
		next_busState  = busState;
		next_ready     = hreadyout;
		next_rdata     = hrdata;
		next_accIdx    = accIdx;
		next_accWrite  = accWrite;
		next_accMapped = accMapped;
		case (busState)
			tx_main_pkg::BUS_IDLE: begin
				if (ahbIn.hsel && hreadyout && ahbIn.htrans[1]) begin
					next_accIdx    = ahbIn.haddr[17:2];
					next_accWrite  = ahbIn.hwrite;
					next_accMapped = ahbIn.haddr[31:18] == 14'h0000 && ahbIn.haddr[1:0] == 2'h0;
					next_ready     = 1'b0;
					next_busState  = tx_main_pkg::BUS_WAIT;
				end
			end
			tx_main_pkg::BUS_WAIT: begin
				next_ready    = 1'b1;
				next_rdata    = accWrite ? 32'h0000_0000 : {24'h00_0000, readByte};
				next_busState = tx_main_pkg::BUS_IDLE;
			end
			default: next_busState = tx_main_pkg::BUS_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			busState  <= tx_main_pkg::BUS_IDLE;
			hreadyout <= 1'b1;
			hrdata    <= 32'h0000_0000;
			hresp     <= 1'b0;
			accIdx    <= 16'h0000;
			accWrite  <= 1'b0;
			accMapped <= 1'b0;
		end else begin
			busState  <= next_busState;
			hreadyout <= next_ready;
			hrdata    <= next_rdata;
			hresp     <= 1'b0;
			accIdx    <= next_accIdx;
			accWrite  <= next_accWrite;
			accMapped <= next_accMapped;
		end
	end

	// ==========================================================
	// Read decode
	always_comb begin
		readByte = 8'h00;
		if (!accMapped)
			readByte = 8'h00;
		else if (accIdx == `IDX_CLOCK_GATE)
			readByte = clockGate;
		else if (accIdx == `IDX_SOFT_RESET)
			readByte = {parAudio, `SOFT_READ_LOW};
		else if (accIdx == `IDX_PROT_CTRL)
			readByte = {2'b00, prot.override, prot.lock, 3'b000, prot.blockBypass};
		else if (accIdx == `IDX_FEED_THROUGH)
			readByte = {7'h00, feedThrough};
		else if (accIdx == `IDX_PHY_RESET)
			readByte = {7'h00, phyReset};
		else if (accIdx == `IDX_PRESENT)
			readByte = present;
		else if (accIdx == `IDX_RETURN_PHY)
			readByte = {7'h00, returnPhyReset};
		else if (accIdx == `IDX_PRESENT2)
			readByte = {7'h00, present2};
		else if (accIdx == `IDX_STATUS)
			readByte = {7'h00, protectVersionSel};
		else if (accIdx == `IDX_DIV_LOW)
			readByte = divLow;
		else if (accIdx == `IDX_DIV_HIGH)
			readByte = {1'b0, divHigh};
	end

	// ==========================================================
	// Register file
	assign presentSet = {laneSeen[`LANE_PAR_AUDIO] & parAudio, laneSeen[0], laneSeen[1], laneSeen[2],
		laneSeen[3], laneSeen[4], 1'b0, laneSeen[`LANE_CONSUMER]};

	always_comb begin
		next_clockGate = clockGate;
		next_prot      = prot;
		next_toggle    = laneResetToggle;
		next_feed      = feedThrough;
		next_phy       = phyReset;
		next_returnPhy = returnPhyReset;
		next_divLow    = divLow;
		next_divHigh   = divHigh;
		next_present   = present & `PRESENT_MASK;
		next_present2  = present2;
		if (wrEn) begin
			if (accIdx == `IDX_CLOCK_GATE)
				next_clockGate = wdata;
			else if (accIdx == `IDX_SOFT_RESET) begin
				for (int b = 0; b < 5; b++) begin
					if (!wdata[b])
						next_toggle[b] = ~laneResetToggle[b];
				end
				if (!wdata[`BIT_CONSUMER])
					next_toggle[`LANE_CONSUMER] = ~laneResetToggle[`LANE_CONSUMER];
				if (!wdata[`BIT_PAR_AUDIO] && parAudio)
					next_toggle[`LANE_PAR_AUDIO] = ~laneResetToggle[`LANE_PAR_AUDIO];
			end else if (accIdx == `IDX_PROT_CTRL) begin
				next_prot.override    = wdata[`BIT_OVERRIDE];
				next_prot.lock        = prot.lock | wdata[`BIT_LOCK];
				next_prot.blockBypass = prot.blockBypass | wdata[`BIT_BLOCK_BYPASS];
			end else if (accIdx == `IDX_FEED_THROUGH)
				next_feed = wdata[0];
			else if (accIdx == `IDX_PHY_RESET)
				next_phy = wdata[0];
			else if (accIdx == `IDX_PRESENT)
				next_present = next_present & ~wdata;
			else if (accIdx == `IDX_RETURN_PHY)
				next_returnPhy = wdata[0];
			else if (accIdx == `IDX_PRESENT2)
				next_present2 = present2 & ~wdata[0];
			else if (accIdx == `IDX_SOFT_RESET2) begin
				if (!wdata[0])
					next_toggle[`LANE_DMA] = ~laneResetToggle[`LANE_DMA];
			end else if (accIdx == `IDX_DIV_LOW)
				next_divLow = wdata;
			else if (accIdx == `IDX_DIV_HIGH)
				next_divHigh = wdata[6:0];
		end
		// Clock detection wins over a same-cycle clear
		next_present  = next_present | presentSet;
		next_present2 = next_present2 | laneSeen[`LANE_DMA];
		// Switch follows override only while unlocked
		next_switch = protectVersionSel;
		if (!prot.lock)
			next_switch = next_prot.override;
	end

	// ==========================================================
	// One-millisecond reference pulse
	always_comb begin
		next_msCount = msCount + 15'h0001;
		next_msPulse = 1'b0;
		if (15'(msCount + 15'h0001) >= {divHigh, divLow}) begin
			next_msCount = 15'h0000;
			next_msPulse = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			clockGate         <= `RST_CLOCK_GATE;
			prot              <= '{`RST_OVERRIDE, `RST_LOCK, `RST_BLOCK_BYPASS};
			laneResetToggle   <= '0;
			protectVersionSel <= `RST_SWITCH;
			feedThrough       <= `RST_FEED_THROUGH;
			phyReset          <= PHY_GEN2;
			returnPhyReset    <= `RST_RETURN_PHY;
			present           <= 8'h00;
			present2          <= 1'b0;
			divLow            <= `RST_DIV_LOW;
			divHigh           <= `RST_DIV_HIGH;
			msCount           <= 15'h0000;
			msPulse           <= 1'b0;
		end else begin
			clockGate         <= next_clockGate;
			prot              <= next_prot;
			laneResetToggle   <= next_toggle;
			protectVersionSel <= next_switch;
			feedThrough       <= next_feed;
			phyReset          <= next_phy;
			returnPhyReset    <= next_returnPhy;
			present           <= next_present;
			present2          <= next_present2;
			divLow            <= next_divLow;
			divHigh           <= next_divHigh;
			msCount           <= next_msCount;
			msPulse           <= next_msPulse;
		end
	end

	// ==========================================================
	// Domain lanes
	assign gateVec  = {clockGate[7], clockGate[6], clockGate[4], clockGate[3], 2'b00, clockGate[5],
		2'b00, clockGate[2:0]};
	assign allowVec = {1'b1, ~prot.blockBypass, {(`LANES-2){1'b0}}};

	for (genvar i = 0; i < `LANES; i++) begin : gLane
		domain_lane domain_lane_i (
			.sys_clk        (sys_clk),
			.rst_b          (rst_b),
			.domainClockPin (domainClockPin[i]),
			.gateRequest    (gateVec[i]),
			.bypassAllow    (allowVec[i]),
			.resetToggle    (laneResetToggle[i]),
			.clockEnable    (laneClockEnable[i]),
			.bypassActive   (laneBypass[i]),
			.domainReset    (laneReset[i]),
			.clockSeen      (laneSeen[i])
		);
	end

	// ==========================================================
	// Checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	gate22_bypass_a: assert property (laneBypass[`LANE_PROT22] == !laneClockEnable[`LANE_PROT22])
		else $error("newer engine bypass not tied to its clock stop");
	gate14_bypass_a: assert property (laneBypass[`LANE_PROT14] |-> !laneClockEnable[`LANE_PROT14])
		else $error("older engine bypassed while clocked");
	pixel_gate_a: assert property ($fell(laneClockEnable[0]) |-> $past(clockGate[0]))
		else $error("pixel clock stopped without its gate bit");
	toggle_write_a: assert property ((wrEn && accIdx == `IDX_SOFT_RESET && !wdata[0])
		|=> laneResetToggle[0] != $past(laneResetToggle[0]))
		else $error("pixel reset request did not toggle");
	soft_read_a: assert property ((busState == tx_main_pkg::BUS_WAIT && !accWrite && accMapped
		&& accIdx == `IDX_SOFT_RESET) |=> hrdata[6:0] == `SOFT_READ_LOW && hrdata[7] == $past(parAudio))
		else $error("reset request register read wrong");
	par_audio_a: assert property ((wrEn && accIdx == `IDX_SOFT_RESET && !parAudio)
		|=> $stable(laneResetToggle[`LANE_PAR_AUDIO]))
		else $error("parallel audio reset toggled while port unused");
	unlocked_switch_a: assert property (!prot.lock |=> protectVersionSel == prot.override)
		else $error("unlocked switch does not follow override");
	locked_switch_a: assert property (prot.lock |=> prot.lock && $stable(protectVersionSel))
		else $error("locked switch moved or lock cleared");
	status_read_a: assert property ((busState == tx_main_pkg::BUS_WAIT && !accWrite && accMapped
		&& accIdx == `IDX_STATUS) |=> hrdata == {31'h0000_0000, protectVersionSel})
		else $error("status read does not show switch");

	soft_reset_c: cover property (wrEn && accIdx == `IDX_SOFT_RESET ##[1:40] laneReset[0]);
	lock_c: cover property ($rose(prot.lock));
	gate22_c: cover property ($rose(laneBypass[`LANE_PROT22]));
	read_c: cover property (busState == tx_main_pkg::BUS_WAIT && !accWrite ##1 hreadyout);

endmodule : tx_main_clock_reset_ctrl

// [testbench/domain_clock_model.sv]
`timescale 1ns/1ns

module domain_clock_model (
	// Pace of the domain clocks
	input  wire logic             slow,
	// Lane signals
	input  wire logic [11:0]      laneReset,
	output logic      [11:0]      domainClockPin,
	output logic      [11:0][7:0] pulseCount
);
	// ============
	// Free running domain clocks, phase unrelated to sys_clk
	for (genvar k = 0; k < 12; k++) begin : gen_lane
		initial begin
			domainClockPin[k] = 1'b0;
			pulseCount[k] = 8'h00;
			forever begin
				#(slow ? 60 + 5 * k : 20 + 2 * k);
				domainClockPin[k] = ~domainClockPin[k];
			end
		end
		// Reset pulses seen by this domain
		always @(posedge laneReset[k]) pulseCount[k] <= pulseCount[k] + 8'h01;
	end
endmodule : domain_clock_model

// [testbench/tx_main_clock_reset_ctrl_tb.sv]
`timescale 1ns/1ns
`include "tx_main_params.svh"

module tx_main_clock_reset_ctrl_tb;
	logic                     sys_clk;
	logic                     rst_b;
	tx_main_pkg::ahb_req_type ahbIn;
	logic                     hreadyout;
	logic [31:0]              hrdata;
	logic                     hresp;
	logic [2:0]               audioInputSelect;
	logic                     slow;
	logic [11:0]              domainClockPin;
	logic [11:0]              laneClockEnable;
	logic [11:0]              laneBypass;
	logic [11:0]              laneReset;
	logic [11:0]              laneResetToggle;
	logic [11:0][7:0]         pulseCount;
	logic                     protectVersionSel;
	logic                     feedThrough;
	logic                     phyReset;
	logic                     returnPhyReset;
	logic                     msPulse;
	logic [7:0]               rd;
	// Stands in for the video config register outside this block
	localparam logic [15:0]   videoConfigIdx = 16'h0100;
	int                       n_mismatch;
	int                       num_checks;

	tx_main_clock_reset_ctrl tx_main_clock_reset_ctrl_i (
		.sys_clk(sys_clk), .rst_b(rst_b), .ahbIn(ahbIn), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .audioInputSelect(audioInputSelect), .domainClockPin(domainClockPin),
		.laneClockEnable(laneClockEnable), .laneBypass(laneBypass), .laneReset(laneReset),
		.laneResetToggle(laneResetToggle), .protectVersionSel(protectVersionSel), .feedThrough(feedThrough),
		.phyReset(phyReset), .returnPhyReset(returnPhyReset), .msPulse(msPulse));

	domain_clock_model domain_clock_model_i (
		.slow(slow), .laneReset(laneReset), .domainClockPin(domainClockPin), .pulseCount(pulseCount));

	always #4 sys_clk = ~sys_clk;

	// ============
	// Reporting
	task automatic results;
		$display("Checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic hang(input string what);
		n_mismatch++;
		$display("BAD %s expected done seen timeout", what);
		results();
	endtask : hang

	// ============
	// Bus and lane helpers, entered just after a rising edge
	task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
		int n;
		ahbIn.hsel <= 1'b1;
		ahbIn.htrans <= 2'h2;
		ahbIn.haddr <= {14'h0000, idx, 2'h0};
		ahbIn.hwrite <= wr;
		ahbIn.hsize <= 3'h2;
		n = 0;
		do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 20);
		ahbIn.htrans <= 2'h0;
		ahbIn.hwdata <= {24'h000000, wd};
		do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 40);
		if (n >= 40)
			hang("bus");
		rd = hrdata[7:0];
		check("hresp", 32'h0, {31'h0, hresp});
	endtask : bus

	task automatic wait_en(input logic [11:0] exp);
		int n;
		for (n = 0; n < 100 && laneClockEnable !== exp; n++) @(posedge sys_clk);
		if (n == 100)
			hang("clock enable");
		check("clock enable", exp, laneClockEnable);
	endtask : wait_en

	// ============
	// Scenarios
	task automatic t_reset_values;
		logic [15:0] idx [10] = '{`IDX_CLOCK_GATE, `IDX_SOFT_RESET, `IDX_PROT_CTRL, `IDX_FEED_THROUGH,
			`IDX_RETURN_PHY, `IDX_SOFT_RESET2, `IDX_STATUS, `IDX_DIV_LOW, `IDX_DIV_HIGH, 16'h4008};
		logic [7:0] exp [10] = '{8'h00, 8'h5f, 8'h20, 8'h00, 8'h01, 8'h00, 8'h01, 8'h93, 8'h69, 8'h00};
		check("clock enable", 12'hfff, laneClockEnable);
		check("version", 1'b1, protectVersionSel);
		bus(1'b1, 16'h4008, 8'hff);
		for (int i = 0; i < 10; i++) begin
			bus(1'b0, idx[i], 8'h00);
			check("reset value", exp[i], rd);
		end
	endtask : t_reset_values

	task automatic t_gates;
		int lane [8] = '{0, 1, 2, 8, 9, 5, 10, 11};
		for (int b = 0; b < 8; b++) begin
			bus(1'b1, `IDX_CLOCK_GATE, 8'h01 << b);
			if (b == 1)
				bus(1'b1, videoConfigIdx, 8'h00);
			wait_en(~(12'h001 << lane[b]));
			check("bypass", b > 5 ? 12'h001 << lane[b] : 12'h000, laneBypass);
			bus(1'b0, `IDX_CLOCK_GATE, 8'h00);
			check("gate readback", 8'h01 << b, rd);
		end
		bus(1'b1, `IDX_CLOCK_GATE, 8'h00);
		wait_en(12'hfff);
		check("bypass off", 12'h000, laneBypass);
	endtask : t_gates

	task automatic t_soft_reset;
		logic [15:0] idx [7] = '{`IDX_SOFT_RESET, `IDX_SOFT_RESET, `IDX_SOFT_RESET, `IDX_SOFT_RESET,
			`IDX_SOFT_RESET, `IDX_SOFT_RESET, `IDX_SOFT_RESET2};
		logic [7:0] data [7] = '{8'hfe, 8'hfd, 8'hfb, 8'hf7, 8'hef, 8'hbf, 8'h00};
		int lane [7] = '{0, 1, 2, 3, 4, 5, 7};
		logic [11:0] tog;
		logic [7:0] cnt;
		int n;
		slow <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			tog = laneResetToggle;
			cnt = pulseCount[lane[i]];
			bus(1'b1, idx[i], data[i]);
			check("toggle", tog ^ (12'h001 << lane[i]), laneResetToggle);
			if (i == 1)
				bus(1'b1, videoConfigIdx, 8'h00);
			for (n = 0; n < 400 && (pulseCount[lane[i]] !== cnt + 8'h01 || laneReset[lane[i]] !== 1'b0); n++)
				@(posedge sys_clk);
			if (n == 400)
				hang("reset pulse");
			repeat (40) @(posedge sys_clk);
			check("pulse count", cnt + 8'h01, pulseCount[lane[i]]);
			bus(1'b0, idx[i], 8'h00);
			check("request readback", i < 6 ? 8'h5f : 8'h00, rd);
			if (i == 5) begin
				bus(1'b1, `IDX_CLOCK_GATE, 8'h10);
				bus(1'b1, `IDX_CLOCK_GATE, 8'h00);
				bus(1'b1, `IDX_CLOCK_GATE, 8'h10);
				bus(1'b1, `IDX_CLOCK_GATE, 8'h00);
			end
		end
		slow <= 1'b0;
	endtask : t_soft_reset

	task automatic t_par_audio;
		logic [11:0] tog;
		tog = laneResetToggle;
		bus(1'b1, `IDX_SOFT_RESET, 8'h7f);
		check("audio toggle idle", tog, laneResetToggle);
		audioInputSelect <= 3'h6;
		bus(1'b0, `IDX_SOFT_RESET, 8'h00);
		check("request read", 8'hdf, rd);
		bus(1'b1, `IDX_SOFT_RESET, 8'h7f);
		check("audio toggle", tog ^ 12'h040, laneResetToggle);
	endtask : t_par_audio

	task automatic t_protect;
		bus(1'b1, `IDX_PROT_CTRL, 8'h00);
		check("version", 1'b0, protectVersionSel);
		bus(1'b0, `IDX_STATUS, 8'h00);
		check("status", 8'h00, rd);
		bus(1'b1, `IDX_PROT_CTRL, 8'h20);
		check("version", 1'b1, protectVersionSel);
		bus(1'b1, `IDX_PROT_CTRL, 8'h10);
		bus(1'b1, `IDX_PROT_CTRL, 8'h30);
		check("locked version", 1'b0, protectVersionSel);
		bus(1'b0, `IDX_PROT_CTRL, 8'h00);
		check("stored override", 8'h30, rd);
		bus(1'b1, `IDX_PROT_CTRL, 8'h20);
		bus(1'b0, `IDX_STATUS, 8'h00);
		check("status", 8'h00, rd);
		bus(1'b1, `IDX_PROT_CTRL, 8'h21);
		bus(1'b0, `IDX_PROT_CTRL, 8'h00);
		check("bypass block", 8'h31, rd);
		bus(1'b1, `IDX_CLOCK_GATE, 8'h40);
		wait_en(12'hbff);
		check("blocked bypass", 12'h000, laneBypass);
		bus(1'b1, `IDX_CLOCK_GATE, 8'h00);
		wait_en(12'hfff);
		rst_b <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		check("version after reset", 1'b1, protectVersionSel);
		bus(1'b1, `IDX_PROT_CTRL, 8'h00);
		check("lock cleared", 1'b0, protectVersionSel);
	endtask : t_protect

	task automatic t_misc;
		int n;
		bus(1'b1, `IDX_FEED_THROUGH, 8'h01);
		bus(1'b1, `IDX_PHY_RESET, 8'h01);
		bus(1'b1, `IDX_RETURN_PHY, 8'h00);
		check("plain outputs", 3'b110, {feedThrough, phyReset, returnPhyReset});
		bus(1'b1, `IDX_DIV_LOW, 8'h04);
		bus(1'b1, `IDX_DIV_HIGH, 8'h00);
		for (n = 0; n < 20 && msPulse !== 1'b1; n++) @(posedge sys_clk);
		@(posedge sys_clk);
		for (n = 1; n < 20 && msPulse !== 1'b1; n++) @(posedge sys_clk);
		check("ms period", 4, n);
		bus(1'b0, `IDX_PRESENT, 8'h00);
		check("clock present", 8'hfd, rd);
		bus(1'b0, `IDX_PRESENT2, 8'h00);
		check("clock present 2", 8'h01, rd);
	endtask : t_misc

	// ============
	// Main sequence
	initial begin
		sys_clk = 1'b0;
		rst_b = 1'b0;
		ahbIn = '0;
		audioInputSelect = 3'h0;
		slow = 1'b0;
		n_mismatch = 0;
		num_checks = 0;
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		t_reset_values();
		t_gates();
		t_soft_reset();
		t_par_audio();
		t_protect();
		t_misc();
		results();
	end
endmodule : tx_main_clock_reset_ctrl_tb
